//--- hdl/soe_cfg.svh
`ifndef SOE_CFG_SVH
`define SOE_CFG_SVH

// ----------------------------------------------------------------
// Serial bus address and framing
// ----------------------------------------------------------------
`define SOE_BUS_ADDR        7'h69
`define SOE_DIR_WRITE       1'h0
`define SOE_LAST_BIT        4'h7
`define SOE_ACK_BIT         4'h8
`define SOE_EARLY_BITS      4'h2
`define SOE_NUM_BYTES       2'h3
`define SOE_RISES_TO_ARM    2'h1

// ----------------------------------------------------------------
// Byte indices of the enable groups
// ----------------------------------------------------------------
`define SOE_GROUP_A_IDX     2'h0
`define SOE_GROUP_B_IDX     2'h1
`define SOE_GROUP_C_IDX     2'h2

// ----------------------------------------------------------------
// Power-up values: every functional enable set
// ----------------------------------------------------------------
`define SOE_GROUP_A_RESET   8'hCF
`define SOE_GROUP_B_RESET   8'hF3
`define SOE_GROUP_C_RESET   8'h40

// ----------------------------------------------------------------
// Field positions inside the groups
// ----------------------------------------------------------------
`define SOE_A_LOW_MSB       3
`define SOE_A_OUT4_BIT      6
`define SOE_A_OUT5_BIT      7
`define SOE_B_LOW_MSB       1
`define SOE_B_HIGH_LSB      4
`define SOE_B_HIGH_MSB      7
`define SOE_C_OUT12_BIT     6

`define SOE_NUM_OUTPUTS     13

`endif

//--- hdl/soe_pkg.sv
package soe_pkg;

   // ----------------------------------------------------------------
   // Link receiver states
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      SOE_ST_IDLE = 2'b00,
      SOE_ST_ADDR = 2'b01,
      SOE_ST_DATA = 2'b10,
      SOE_ST_SKIP = 2'b11
   } soe_link_state_e;

   // ----------------------------------------------------------------
   // Enable groups as one carrier
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] group_c;
      logic [7:0] group_b;
      logic [7:0] group_a;
   } soe_groups_s;

   // ----------------------------------------------------------------
   // Link domain state, clocked by the serial clock
   // ----------------------------------------------------------------
   typedef struct packed {
      soe_link_state_e state;
      logic [3:0]      bit_cnt;
      logic [7:0]      shift;
      logic [1:0]      byte_idx;
      logic            acked;
      logic            sda_oe_n;
      logic [7:0]      xfer_byte;
      logic [1:0]      xfer_idx;
      logic            xfer_tog;
   } soe_link_s;

   // ----------------------------------------------------------------
   // Core domain state, clocked by the input clock
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [1:0]  scl_sync;
      logic [1:0]  sda_sync;
      logic        scl_q;
      logic        sda_q;
      logic        pend;
      logic [1:0]  rise_cnt;
      logic [1:0]  xfer_sync;
      logic        acc_tog;
      soe_groups_s groups;
   } soe_core_s;

endpackage

//--- hdl/soe_clk_gate.sv
`timescale 1ns/1ns

module soe_clk_gate #(
   parameter int WIDTH = 13
) (
   // Clock and reset
   input  wire logic             i_clk,
   input  wire logic             i_resetn,
   // Enables from the register bank
   input  wire logic [WIDTH-1:0] i_enable,
   // Gated clock copies
   output logic      [WIDTH-1:0] o_clk
);

   logic [WIDTH-1:0] en_reg;
   logic [WIDTH-1:0] en_next;

   // ----------------------------------------------------------------
   // Enable stage, loaded while the clock is low
   // ----------------------------------------------------------------
   always_comb begin
      if (!i_resetn) begin
         en_next = {WIDTH{1'b1}};
      end else begin
         en_next = i_enable;
      end
   end

   always_ff @(negedge i_clk) begin
      en_reg <= en_next; // see RULE_09
   end

   // ----------------------------------------------------------------
   // Gate: a disabled copy stays low, changes land in the low phase
   // ----------------------------------------------------------------
   assign o_clk = {WIDTH{i_clk}} & en_reg; // see RULE_01 see RULE_09

endmodule

//--- hdl/soe_bank.sv
`timescale 1ns/1ns
`include "soe_cfg.svh"

// Operation
// RULE_01: Each of the thirteen outputs is a copy of the input clock while its enable bit is set.
// RULE_02: Configuration bytes arrive from byte 0 upward, each byte most significant bit first.
// RULE_03: The host writes zero to reserved bits, and those bits have no effect here.
// RULE_04: Only the seven-bit address 1101001 followed by a write direction bit is answered.
// RULE_05: Byte 0 bits 0 to 3 enable outputs 0 to 3, bit 6 output 4, bit 7 output 5, bits 4 and 5 reserved.
// RULE_06: Byte 1 bits 0 and 1 enable outputs 6 and 7, bits 4 to 7 outputs 8 to 11, bits 2 and 3 reserved.
// RULE_07: Byte 2 bit 6 enables output 12 and every other bit of it is reserved.
// RULE_08: After reset every output enable is set so all outputs toggle before any write.
// RULE_09: A disabled output is held low and enable changes are applied glitch free in the clock's low phase.
// RULE_10: A byte takes effect only after it is fully received and acknowledged; unsent bytes keep their value.

module soe_bank (
   // Input clock and reset
   input  wire logic                        i_mclk,
   input  wire logic                        i_resetn,
   // Serial link
   input  wire logic                        i_sclk,
   input  wire logic                        i_serial_data_line,
   output logic                             o_serial_data_line,
   output logic                             o_serial_data_line_oe_n,
   // Clock outputs
   output logic [`SOE_NUM_OUTPUTS-1:0]      o_clk_out
);

   // ----------------------------------------------------------------
   // Enable mapping
   // ----------------------------------------------------------------
   function automatic logic [`SOE_NUM_OUTPUTS-1:0] soe_map_enables(input soe_pkg::soe_groups_s g);
      soe_map_enables = {g.group_c[`SOE_C_OUT12_BIT],                  // see RULE_07
                         g.group_b[`SOE_B_HIGH_MSB:`SOE_B_HIGH_LSB],   // see RULE_06
                         g.group_b[`SOE_B_LOW_MSB:0],                  // see RULE_06
                         g.group_a[`SOE_A_OUT5_BIT],                   // see RULE_05
                         g.group_a[`SOE_A_OUT4_BIT],                   // see RULE_05
                         g.group_a[`SOE_A_LOW_MSB:0]};                 // see RULE_05 see RULE_03
   endfunction

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   soe_pkg::soe_core_s core_reg;
   soe_pkg::soe_core_s core_next;
   soe_pkg::soe_link_s link_reg;
   soe_pkg::soe_link_s link_next;

   logic [7:0]                 full_byte;
   logic                       early_addr;
   logic                       ack_now;
   logic                       scl_rise;
   logic                       start_cond;
   logic                       stop_cond;
   logic [`SOE_NUM_OUTPUTS-1:0] enables;

   // ----------------------------------------------------------------
   // Link domain: bits sampled and acknowledge driven on the falling
   // serial clock edge. This domain has no reset of its own: the core
   // holds pend high from reset and after every stop or start, and the
   // first falling edge with pend high starts a clean frame.
   // ----------------------------------------------------------------
   always_comb begin
      link_next  = link_reg;
      full_byte  = {link_reg.shift[6:0], i_serial_data_line}; // see RULE_02
      early_addr = (link_reg.state == soe_pkg::SOE_ST_ADDR) && (link_reg.bit_cnt <= `SOE_EARLY_BITS);
      ack_now    = 1'b0;
      // Pend is quasi-static here: it settles long before the edges that read it
      if (early_addr || !core_reg.pend) begin
         case (link_reg.state)
            soe_pkg::SOE_ST_ADDR,
            soe_pkg::SOE_ST_DATA,
            soe_pkg::SOE_ST_SKIP: begin
               if (link_reg.bit_cnt == `SOE_ACK_BIT) begin
                  link_next.bit_cnt  = 4'h0;
                  link_next.sda_oe_n = 1'b1;
                  if (link_reg.state == soe_pkg::SOE_ST_ADDR) begin
                     link_next.state = link_reg.acked ? soe_pkg::SOE_ST_DATA : soe_pkg::SOE_ST_SKIP;
                  end else if (link_reg.state == soe_pkg::SOE_ST_DATA && link_reg.byte_idx < `SOE_NUM_BYTES) begin
                     link_next.xfer_byte = link_reg.shift;   // see RULE_10
                     link_next.xfer_idx  = link_reg.byte_idx; // see RULE_02
                     link_next.xfer_tog  = ~link_reg.xfer_tog; // see RULE_10
                     link_next.byte_idx  = link_reg.byte_idx + 2'h1;
                  end
               end else begin
                  link_next.shift   = full_byte; // see RULE_02
                  link_next.bit_cnt = link_reg.bit_cnt + 4'h1;
                  if (link_reg.bit_cnt == `SOE_LAST_BIT) begin
                     if (link_reg.state == soe_pkg::SOE_ST_ADDR) begin
                        ack_now = (full_byte[7:1] == `SOE_BUS_ADDR) && (full_byte[0] == `SOE_DIR_WRITE); // see RULE_04
                     end else begin
                        ack_now = (link_reg.state == soe_pkg::SOE_ST_DATA);
                     end
                     link_next.acked    = ack_now;
                     link_next.sda_oe_n = ~ack_now;
                  end
               end
            end
            soe_pkg::SOE_ST_IDLE: begin
               link_next.sda_oe_n = 1'b1;
            end
            default: begin
               link_next.state = soe_pkg::SOE_ST_IDLE;
            end
         endcase
      end else begin
         // Start of frame: realign the toggle with the core so no event is faked
         link_next.state     = soe_pkg::SOE_ST_ADDR;
         link_next.bit_cnt   = 4'h0;
         link_next.shift     = 8'h00;
         link_next.byte_idx  = 2'h0;
         link_next.acked     = 1'b0;
         link_next.sda_oe_n  = 1'b1;
         link_next.xfer_byte = 8'h00;
         link_next.xfer_idx  = 2'h0;
         link_next.xfer_tog  = core_reg.acc_tog;
      end
   end

   always_ff @(negedge i_sclk) begin
      link_reg <= link_next;
   end

   // ----------------------------------------------------------------
   // Core domain: bus watch, byte capture and enable bank
   // ----------------------------------------------------------------
   always_comb begin
      core_next           = core_reg;
      core_next.scl_sync  = {core_reg.scl_sync[0], i_sclk};
      core_next.sda_sync  = {core_reg.sda_sync[0], i_serial_data_line};
      core_next.scl_q     = core_reg.scl_sync[1];
      core_next.sda_q     = core_reg.sda_sync[1];
      core_next.xfer_sync = {core_reg.xfer_sync[0], link_reg.xfer_tog};
      scl_rise   = core_reg.scl_sync[1] && !core_reg.scl_q;
      start_cond = core_reg.scl_sync[1] && core_reg.scl_q && core_reg.sda_q && !core_reg.sda_sync[1];
      stop_cond  = core_reg.scl_sync[1] && core_reg.scl_q && !core_reg.sda_q && core_reg.sda_sync[1];

      // Frame boundary: re-arm the link, release it after the second rise
      if (start_cond || stop_cond) begin
         core_next.pend     = 1'b1;
         core_next.rise_cnt = 2'h0;
      end else if (core_reg.pend && scl_rise) begin
         if (core_reg.rise_cnt == `SOE_RISES_TO_ARM) begin
            core_next.pend = 1'b0;
         end
         core_next.rise_cnt = core_reg.rise_cnt + 2'h1;
      end

      // Byte hand-over; the link holds byte and index for a full byte time
      if (core_reg.xfer_sync[1] != core_reg.acc_tog) begin
         core_next.acc_tog = core_reg.xfer_sync[1];
         case (link_reg.xfer_idx)
            `SOE_GROUP_A_IDX: begin
               core_next.groups.group_a = link_reg.xfer_byte; // see RULE_10
            end
            `SOE_GROUP_B_IDX: begin
               core_next.groups.group_b = link_reg.xfer_byte; // see RULE_10
            end
            `SOE_GROUP_C_IDX: begin
               core_next.groups.group_c = link_reg.xfer_byte; // see RULE_10
            end
            default: begin
               core_next.groups = core_reg.groups;
            end
         endcase
      end

      if (!i_resetn) begin
         core_next.scl_sync       = 2'h3;
         core_next.sda_sync       = 2'h3;
         core_next.scl_q          = 1'b1;
         core_next.sda_q          = 1'b1;
         core_next.pend           = 1'b1;
         core_next.rise_cnt       = 2'h0;
         core_next.xfer_sync      = 2'h0;
         core_next.acc_tog        = 1'b0;
         core_next.groups.group_a = `SOE_GROUP_A_RESET; // see RULE_08
         core_next.groups.group_b = `SOE_GROUP_B_RESET; // see RULE_08
         core_next.groups.group_c = `SOE_GROUP_C_RESET; // see RULE_08
      end
   end

   always_ff @(posedge i_mclk) begin
      core_reg <= core_next;
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign enables                 = soe_map_enables(core_reg.groups); // see RULE_01
   assign o_serial_data_line      = 1'b0;
   assign o_serial_data_line_oe_n = link_reg.sda_oe_n | core_reg.pend;

   soe_clk_gate #(
      .WIDTH    (`SOE_NUM_OUTPUTS)
   ) u_gate (
      .i_clk    (i_mclk),
      .i_resetn (i_resetn),
      .i_enable (enables),
      .o_clk    (o_clk_out)
   );

endmodule

//--- testbench/soe_bank_checker.sv
`timescale 1ns/1ns
`include "soe_cfg.svh"

module soe_bank_checker (
   // Clocks and reset
   input wire logic                        i_mclk,
   input wire logic                        i_resetn,
   input wire logic                        i_sclk,
   // Serial link
   input wire logic                        i_serial_data_line,
   input wire logic                        o_serial_data_line,
   input wire logic                        o_serial_data_line_oe_n,
   // Clock outputs
   input wire logic [`SOE_NUM_OUTPUTS-1:0] o_clk_out
);
   // ----------------------------------------------------------------
   // Frame tracking
   // ----------------------------------------------------------------
   logic       start_tog = 1'b0;
   logic       seen_tog  = 1'b0;
   logic       addr_ok   = 1'b0;
   logic       oe_q      = 1'b1;
   logic [5:0] fall_cnt  = 6'h00;
   logic [7:0] sh        = 8'h00;
   logic [7:0] since_ack = 8'hFF;

   always @(negedge i_serial_data_line) if (i_sclk) start_tog <= ~start_tog;

   always @(negedge i_sclk) begin
      seen_tog <= start_tog;
      fall_cnt <= (start_tog != seen_tog) ? 6'h01 : fall_cnt + 6'h01;
      sh       <= {sh[6:0], i_serial_data_line};
      if (fall_cnt == 6'h09) addr_ok <= (sh == 8'hD2);
   end

   // Cycles since the device last released an acknowledge
   always_ff @(posedge i_mclk) begin
      oe_q      <= o_serial_data_line_oe_n;
      since_ack <= (o_serial_data_line_oe_n && !oe_q) ? 8'h00 :
                   (since_ack == 8'hFF) ? since_ack : since_ack + 8'h01;
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   a_drive_zero: assert property (@(posedge i_mclk) disable iff (!i_resetn) o_serial_data_line == 1'b0)
      else $error("serial drive value not zero");
   a_low_phase: assert property (@(posedge i_mclk) disable iff (!i_resetn) o_clk_out == '0)
      else $error("output high while input clock low");
   a_power_on: assert property (@(negedge i_mclk) disable iff (!i_resetn) $rose(i_resetn) |-> (&o_clk_out) [*8])
      else $error("outputs not all enabled after reset");
   a_ack_once: assert property (@(negedge i_sclk) disable iff (!i_resetn) !o_serial_data_line_oe_n |=> o_serial_data_line_oe_n)
      else $error("acknowledge longer than one serial clock");
   a_ack_slot: assert property (@(negedge i_sclk) disable iff (!i_resetn) !o_serial_data_line_oe_n |-> fall_cnt inside {6'h09, 6'h12, 6'h1B, 6'h24, 6'h2D})
      else $error("acknowledge outside the ninth bit");
   a_addr_match: assert property (@(negedge i_sclk) disable iff (!i_resetn) fall_cnt == 6'h09 |-> o_serial_data_line_oe_n == (sh != 8'hD2))
      else $error("address acknowledge wrong");
   a_data_ack: assert property (@(negedge i_sclk) disable iff (!i_resetn) addr_ok && fall_cnt inside {6'h12, 6'h1B, 6'h24} |-> !o_serial_data_line_oe_n)
      else $error("data byte not acknowledged");
   a_late_change: assert property (@(negedge i_mclk) disable iff (!i_resetn) !$stable(o_clk_out) |-> since_ack < 8'h0A)
      else $error("enables changed without a finished byte");

   c_ack: cover property (@(negedge i_sclk) !o_serial_data_line_oe_n);
   c_refused: cover property (@(negedge i_sclk) fall_cnt == 6'h09 && o_serial_data_line_oe_n);
   c_change: cover property (@(negedge i_mclk) !$stable(o_clk_out));
endmodule

bind soe_bank soe_bank_checker soe_bank_checker_inst (
   .i_mclk                  (i_mclk),
   .i_resetn                (i_resetn),
   .i_sclk                  (i_sclk),
   .i_serial_data_line      (i_serial_data_line),
   .o_serial_data_line      (o_serial_data_line),
   .o_serial_data_line_oe_n (o_serial_data_line_oe_n),
   .o_clk_out               (o_clk_out)
);

//--- testbench/soe_host_model.sv
`timescale 1ns/1ns

module soe_host_model (
   // Serial link toward the device
   output logic      o_sclk,
   output logic      o_sda_low,
   input  wire logic i_sda
);
   initial begin
      o_sclk    = 1'b1;
      o_sda_low = 1'b0;
   end

   // Data set after the falling edge, line read just before the next one
   task automatic clock_bit(input logic b, input int slow, output logic seen);
      #5 o_sda_low = !b;
      #(10 + slow) o_sclk = 1'b1;
      #15 seen = i_sda;
      o_sclk = 1'b0;
   endtask

   task automatic send_frame(input logic [7:0] adr, input logic [31:0] d, input int n, input int slow,
                             output logic [4:0] acks);
      logic [39:0] fr;
      logic        seen;
      fr        = {d, adr};
      acks      = 5'h00;
      o_sda_low = 1'b1;
      #15 o_sclk = 1'b0;
      for (int k = 0; k <= n; k++) begin
         for (int i = 7; i >= 0; i--) clock_bit(fr[8*k+i], slow, seen);
         clock_bit(1'b1, slow, seen);
         acks[k] = !seen;
      end
      #5 o_sda_low = 1'b1;
      #10 o_sclk = 1'b1;
      #20 o_sda_low = 1'b0;
      #30;
   endtask
endmodule

//--- testbench/serial_output_enable_bank_tb.sv
`timescale 1ns/1ns

module serial_output_enable_bank_tb;
   logic        i_mclk    = 1'b0;
   logic        i_resetn  = 1'b0;
   logic        sclk;
   logic        host_low;
   logic        dev_sda;
   logic        dev_oe_n;
   logic [12:0] clk_out;
   logic [7:0]  grp [3];
   int          err_total = 0;
   int          n_tests   = 0;
   wire logic   sda = !(host_low || (!dev_oe_n && !dev_sda));

   soe_bank soe_bank_inst (
      .i_mclk                  (i_mclk),
      .i_resetn                (i_resetn),
      .i_sclk                  (sclk),
      .i_serial_data_line      (sda),
      .o_serial_data_line      (dev_sda),
      .o_serial_data_line_oe_n (dev_oe_n),
      .o_clk_out               (clk_out)
   );

   soe_host_model soe_host_model_inst (
      .o_sclk    (sclk),
      .o_sda_low (host_low),
      .i_sda     (sda)
   );

   always #5 i_mclk = ~i_mclk;

   // ----------------------------------------------------------------
   // Expectations and comparisons
   // ----------------------------------------------------------------
   function automatic logic [12:0] map_en(input logic [7:0] a, b, c);
      return {c[6], b[7:4], b[1:0], a[7:6], a[3:0]};
   endfunction

   task automatic cmp_en(input logic [12:0] exp, got);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH enables expected %h seen %h", exp, got);
      end
   endtask

   task automatic cmp_ack(input logic [4:0] exp, got);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH acks expected %h seen %h", exp, got);
      end
   endtask

   // Output levels in the high phase of the input clock are the enables
   task automatic read_en(output logic [12:0] v);
      @(posedge i_mclk);
      #2 v = clk_out;
   endtask

   task automatic frame(input logic [7:0] adr, input logic [31:0] d, input int n);
      logic [4:0]  acks;
      logic [12:0] v;
      logic        ok;
      ok = (adr == 8'hD2);
      soe_host_model_inst.send_frame(adr, d, n, 0, acks);
      if (ok) for (int k = 0; k < n && k < 3; k++) grp[k] = d[8*k +: 8];
      cmp_ack(ok ? 5'((1 << (n + 1)) - 1) : 5'h00, acks);
      repeat (10) @(posedge i_mclk);
      read_en(v);
      cmp_en(map_en(grp[0], grp[1], grp[2]), v);
      $display("test %0d done", n_tests);
   endtask

   task automatic wrap_up;
      $display("compares %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      logic [12:0] v;
      void'($urandom(10494));
      grp = '{8'hCF, 8'hF3, 8'h40};
      repeat (8) @(negedge i_mclk);
      i_resetn = 1'b1;
      repeat (4) @(negedge i_mclk);
      read_en(v);
      cmp_en(13'h1FFF, v);
      frame(8'hD2, 32'h00000000, 3);
      frame(8'hD0, 32'h0040F3CF, 3);
      frame(8'hD3, 32'h0040F3CF, 3);
      frame(8'hD2, 32'h0F0040C1, 4);
      frame(8'hD2, 32'h00000001, 1);
      // Reserved bits kept at zero by the host
      for (int t = 0; t < 12; t++) frame(8'hD2, $urandom & 32'h0040F3CF, $urandom_range(1, 3));
      wrap_up();
   end

   initial begin
      #400000;
      err_total++;
      $display("watchdog expired");
      wrap_up();
   end
endmodule
